// ### hdl/parallel_port_gpib_sender.sv
/*
 * Printer-style port adapter: host writes bytes over APB, each is sent to a listening instrument.
 * Assumes an APB master on clk, and open-drain instrument bus pins resolved outside.
 */
// Functional notes
// - Each accepted byte yields one acknowledge pulse.
// - Bus side: eight data, three handshake, five management.
// - Seven-bit code; DIO8 passed through or parity.
// - Only the system controller makes itself active.
// - Strobe rise latches byte; source handshake starts once select-in is set.
// - Enabled acknowledge release raises interrupt request.
// - Control register write-only, bits 7..5 ignored.
// - Init bit set then cleared reinitialises.
`timescale 1ns/1ns
module parallel_port_gpib_sender
	import lpt_bus_pkg::*;
#(
	parameter int IFC_CYCLES_P = IFC_CYCLES
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire gpib_in_t bus_in,
	output gpib_pins_t bus_out,
	output gpib_pins_t bus_oe,
	output logic irq
);
	typedef enum logic [2:0] {ST_CLEAR, ST_IDLE, ST_WAIT_SELECT, ST_ADDR, ST_DATA, ST_ACK} eng_state_t;
	eng_state_t state_q;
	logic [7:0] data_q;
	logic [7:0] latch_q;
	logic [4:0] ctrl_q;
	logic [5:0] config_q;
	logic strobe_prev_q;
	logic init_prev_q;
	logic addressed_q;
	logic busy_n_q;
	logic ack_n_q;
	logic [15:0] count_q;
	logic hs_start_q;
	logic [7:0] hs_byte_q;
	logic [7:0] dio_oe;
	logic dav_oe;
	logic hs_done;
	logic access;
	logic wr_now;
	logic strobe_rise;
	logic reinit;
	logic [7:0] status;

	// ************************************************************
	// APB slave: one wait state, registered answer.
	// ************************************************************
	assign access = psel && penable;
	assign wr_now = access && pready && pwrite;
	assign status = {busy_n_q, ack_n_q, 1'b0, !bus_oe.atn, 1'b1, 3'h0};

	always_ff @(posedge clk) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= access && !pready;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			if (access && !pready) begin
				case (paddr)
					DATA_ADDR: prdata <= {24'h00_0000, data_q};
					STATUS_ADDR: prdata <= {24'h00_0000, status};
					CTRL_ADDR: prdata <= 32'h0000_0000;
					CONFIG_ADDR: prdata <= {26'h000_0000, config_q};
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			data_q <= 8'h00;
			ctrl_q <= CTRL_RESET;
			config_q <= CONFIG_RESET;
		end else if (wr_now) begin
			if (paddr == DATA_ADDR) begin
				data_q <= pwdata[7:0];
			end
			if (paddr == CTRL_ADDR) begin
				ctrl_q <= pwdata[CTRL_WIDTH-1:0];
			end
			if (paddr == CONFIG_ADDR) begin
				config_q <= pwdata[CFG_PARITY:0];
			end
		end
	end

	// ************************************************************
	// Control edges.
	// ************************************************************
	assign strobe_rise = ctrl_q[CTRL_STROBE] && !strobe_prev_q;
	assign reinit = !ctrl_q[CTRL_INIT] && init_prev_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			strobe_prev_q <= 1'b0;
			init_prev_q <= 1'b0;
		end else begin
			strobe_prev_q <= ctrl_q[CTRL_STROBE];
			init_prev_q <= ctrl_q[CTRL_INIT];
		end
	end

	// ************************************************************
	// Send engine.
	// ************************************************************
	// A strobe that rises while busy is dropped: the host is expected to poll not-busy first.
	always_ff @(posedge clk) begin
		if (rst || reinit) begin
			state_q <= ST_CLEAR;
			count_q <= 16'(IFC_CYCLES_P);
			latch_q <= 8'h00;
			addressed_q <= 1'b0;
			busy_n_q <= 1'b0;
			ack_n_q <= 1'b1;
			hs_start_q <= 1'b0;
			hs_byte_q <= 8'h00;
		end else begin
			hs_start_q <= 1'b0;
			case (state_q)
				ST_CLEAR: begin
					if (count_q != 16'h0000) begin
						count_q <= count_q - 16'h0001;
					end else begin
						busy_n_q <= 1'b1;
						state_q <= ST_IDLE;
					end
				end
				ST_IDLE: begin
					if (strobe_rise) begin
						latch_q <= data_q;
						busy_n_q <= 1'b0;
						state_q <= ST_WAIT_SELECT;
					end
				end
				ST_WAIT_SELECT: begin
					if (ctrl_q[CTRL_SELECT_IN]) begin
						hs_start_q <= 1'b1;
						if (addressed_q) begin
							hs_byte_q <= encode_byte(latch_q, config_q[CFG_PARITY]);
							state_q <= ST_DATA;
						end else begin
							hs_byte_q <= LISTEN_BASE | {3'h0, config_q[CFG_ADDR_MSB:CFG_ADDR_LSB]};
							state_q <= ST_ADDR;
						end
					end
				end
				ST_ADDR: begin
					if (hs_done) begin
						addressed_q <= 1'b1;
						hs_start_q <= 1'b1;
						hs_byte_q <= encode_byte(latch_q, config_q[CFG_PARITY]);
						state_q <= ST_DATA;
					end
				end
				ST_DATA: begin
					if (hs_done) begin
						ack_n_q <= 1'b0;
						count_q <= 16'(ACK_CYCLES);
						state_q <= ST_ACK;
					end
				end
				ST_ACK: begin
					if (count_q != 16'h0000) begin
						count_q <= count_q - 16'h0001;
					end else begin
						ack_n_q <= 1'b1;
						busy_n_q <= 1'b1;
						state_q <= ST_IDLE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	source_handshake u_source (
		.clk(clk),
		.rst(rst || reinit),
		.start(hs_start_q),
		.tx_byte(hs_byte_q),
		.nrfd_pin(bus_in.nrfd),
		.ndac_pin(bus_in.ndac),
		.dio_oe(dio_oe),
		.dav_oe(dav_oe),
		.done(hs_done)
	);

	// ************************************************************
	// Bus pins and interrupt request.
	// ************************************************************
	// The adapter is system controller, so it takes control with an IFC pulse after every reset.
	always_ff @(posedge clk) begin
		if (rst) begin
			bus_out <= '0;
			bus_oe <= '0;
			irq <= 1'b0;
		end else begin
			bus_out <= '0;
			bus_oe.dio <= dio_oe;
			bus_oe.dav <= dav_oe;
			bus_oe.atn <= (state_q == ST_ADDR);
			bus_oe.eoi <= 1'b0;
			bus_oe.ifc <= (state_q == ST_CLEAR) && !reinit;
			bus_oe.ren <= 1'b1;
			irq <= ctrl_q[CTRL_ACK_IE] && !ack_n_q && (state_q == ST_ACK) && (count_q == 16'h0000);
		end
	end

	// ************************************************************
	// Checks.
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_strobe_taken;
		state_q == ST_IDLE && strobe_rise;
	endsequence
	sequence s_busy_then_select;
		!busy_n_q ##1 state_q == ST_WAIT_SELECT;
	endsequence

	property p_strobe_busy;
		s_strobe_taken |=> s_busy_then_select or (!busy_n_q && state_q == ST_WAIT_SELECT);
	endproperty
	a_strobe_busy: assert property (p_strobe_busy) else $error("strobe did not make the port busy");

	property p_latch;
		s_strobe_taken |=> latch_q == $past(data_q);
	endproperty
	a_latch: assert property (p_latch) else $error("data not latched on strobe");

	property p_ack_after_done;
		state_q == ST_DATA && hs_done |=> !ack_n_q && !busy_n_q;
	endproperty
	a_ack_after_done: assert property (p_ack_after_done) else $error("no acknowledge after byte");

	property p_ack_width;
		$fell(ack_n_q) |-> !ack_n_q [*8];
	endproperty
	a_ack_width: assert property (p_ack_width) else $error("acknowledge pulse too short");

	property p_release_together;
		$rose(ack_n_q) |-> $rose(busy_n_q);
	endproperty
	a_release_together: assert property (p_release_together) else $error("not-busy and acknowledge split");

	property p_irq_enabled;
		$rose(ack_n_q) && $past(ctrl_q[CTRL_ACK_IE]) |-> $rose(irq);
	endproperty
	a_irq_enabled: assert property (p_irq_enabled) else $error("enabled acknowledge gave no request");

	property p_irq_gated;
		irq |-> $past(ctrl_q[CTRL_ACK_IE]) ##1 !irq;
	endproperty
	a_irq_gated: assert property (p_irq_gated) else $error("request without enable or too long");

	property p_ctrl_read_zero;
		access && !pready && !pwrite && paddr == CTRL_ADDR |=> prdata == 32'h0000_0000 && pready;
	endproperty
	a_ctrl_read_zero: assert property (p_ctrl_read_zero) else $error("control register readable");

	property p_reinit;
		reinit |=> state_q == ST_CLEAR && !addressed_q ##1 bus_oe.ifc;
	endproperty
	a_reinit: assert property (p_reinit) else $error("init sequence did not reinitialise");

	property p_parity;
		state_q == ST_DATA && hs_start_q && config_q[CFG_PARITY] |-> hs_byte_q[7] == ^hs_byte_q[6:0];
	endproperty
	a_parity: assert property (p_parity) else $error("parity bit wrong");

endmodule // parallel_port_gpib_sender

// ### hdl/lpt_bus_pkg.sv
/*
 * Shared constants, register map, pin carriers and helpers for the parallel port to instrument bus sender.
 * Assumes a single 100 MHz clock and an APB register port with 32-bit data.
 */
package lpt_bus_pkg;

	// ************************************************************
	// Timing.
	// ************************************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int SETTLE_TIME_NS = 2000;
	localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACK_TIME_NS = 5000;
	localparam int ACK_CYCLES = (ACK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int IFC_TIME_US = 100;
	localparam int IFC_CYCLES = (IFC_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ************************************************************
	// Register map: index, and byte address four times the index.
	// ************************************************************
	localparam int DATA_IDX = 0;
	localparam int STATUS_IDX = 1;
	localparam int CTRL_IDX = 2;
	localparam int CONFIG_IDX = 3;
	localparam logic [11:0] DATA_ADDR = 12'(DATA_IDX * 4);
	localparam logic [11:0] STATUS_ADDR = 12'(STATUS_IDX * 4);
	localparam logic [11:0] CTRL_ADDR = 12'(CTRL_IDX * 4);
	localparam logic [11:0] CONFIG_ADDR = 12'(CONFIG_IDX * 4);

	localparam int CTRL_STROBE = 0;
	localparam int CTRL_AUTO_FEED = 1;
	localparam int CTRL_INIT = 2;
	localparam int CTRL_SELECT_IN = 3;
	localparam int CTRL_ACK_IE = 4;
	localparam int CTRL_WIDTH = 5;
	localparam logic [4:0] CTRL_RESET = 5'h00;

	localparam int STAT_ERROR_N = 3;
	localparam int STAT_SELECT = 4;
	localparam int STAT_PAPER_END = 5;
	localparam int STAT_ACK_N = 6;
	localparam int STAT_BUSY_N = 7;

	localparam int CFG_ADDR_LSB = 0;
	localparam int CFG_ADDR_MSB = 4;
	localparam int CFG_PARITY = 5;
	localparam logic [5:0] CONFIG_RESET = 6'h01;
	localparam logic [7:0] LISTEN_BASE = 8'h20;

	// ************************************************************
	// Instrument bus pin carriers.
	// ************************************************************
	typedef struct packed {
		logic [7:0] dio;
		logic dav;
		logic atn;
		logic eoi;
		logic ifc;
		logic ren;
	} gpib_pins_t;

	typedef struct packed {
		logic nrfd;
		logic ndac;
		logic srq;
	} gpib_in_t;

	// Seven-bit code with DIO8 either passed through or replaced by even parity.
	function automatic logic [7:0] encode_byte(input logic [7:0] value, input logic parity_en);
		encode_byte = {parity_en ? ^value[6:0] : value[7], value[6:0]};
	endfunction

endpackage

// ### hdl/source_handshake.sv
/*
 * Three-wire source handshake for one byte on the instrument bus.
 * Assumes the handshake pins arrive asynchronously and are open drain, low meaning true.
 */
`timescale 1ns/1ns
module source_handshake
	import lpt_bus_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic [7:0] tx_byte,
	input wire logic nrfd_pin,
	input wire logic ndac_pin,
	output logic [7:0] dio_oe,
	output logic dav_oe,
	output logic done
);
	typedef enum logic [1:0] {HS_IDLE, HS_SETTLE, HS_VALID, HS_RELEASE} hs_state_t;
	hs_state_t state_q;
	logic [2:0] nrfd_s_q;
	logic [2:0] ndac_s_q;
	logic nrfd_true_q;
	logic ndac_true_q;
	logic [15:0] settle_q;

	// ************************************************************
	// Pin filters: a change counts once the second and third stages agree.
	// ************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			nrfd_s_q <= 3'h0;
			ndac_s_q <= 3'h0;
			nrfd_true_q <= 1'b0;
			ndac_true_q <= 1'b0;
		end else begin
			nrfd_s_q <= {nrfd_s_q[1:0], ~nrfd_pin};
			ndac_s_q <= {ndac_s_q[1:0], ~ndac_pin};
			if (nrfd_s_q[1] == nrfd_s_q[2]) begin
				nrfd_true_q <= nrfd_s_q[2];
			end
			if (ndac_s_q[1] == ndac_s_q[2]) begin
				ndac_true_q <= ndac_s_q[2];
			end
		end
	end

	// ************************************************************
	// Handshake sequence.
	// ************************************************************
	// With no listener on the bus both lines float false and the sequence waits in HS_SETTLE.
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= HS_IDLE;
			dio_oe <= 8'h00;
			dav_oe <= 1'b0;
			done <= 1'b0;
			settle_q <= 16'h0000;
		end else begin
			done <= 1'b0;
			case (state_q)
				HS_IDLE: begin
					if (start) begin
						dio_oe <= tx_byte;
						settle_q <= 16'(SETTLE_CYCLES);
						state_q <= HS_SETTLE;
					end
				end
				HS_SETTLE: begin
					if (settle_q != 16'h0000) begin
						settle_q <= settle_q - 16'h0001;
					end else if (!nrfd_true_q && ndac_true_q) begin
						dav_oe <= 1'b1;
						state_q <= HS_VALID;
					end
				end
				HS_VALID: begin
					if (!ndac_true_q) begin
						dav_oe <= 1'b0;
						state_q <= HS_RELEASE;
					end
				end
				HS_RELEASE: begin
					dio_oe <= 8'h00;
					done <= 1'b1;
					state_q <= HS_IDLE;
				end
				default: begin
					state_q <= HS_IDLE;
				end
			endcase
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_dav_needs_ready;
		$rose(dav_oe) |-> !$past(nrfd_true_q) && $past(ndac_true_q);
	endproperty
	a_dav_needs_ready: assert property (p_dav_needs_ready) else $error("valid raised without ready listeners");

	property p_done_after_dav;
		$fell(dav_oe) |=> done ##1 !done && dio_oe == 8'h00;
	endproperty
	a_done_after_dav: assert property (p_done_after_dav) else $error("byte completion not flagged");

endmodule // source_handshake

// ### tb/bus_listener.sv
/*
 * Instrument bus listener that accepts every byte the adapter sources.
 * Assumes open-drain handshake lines with pull-ups, and enables from the adapter meaning "line true".
 */
`timescale 1ns/1ns
module bus_listener
	import lpt_bus_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire gpib_pins_t bus_oe,
	output gpib_in_t bus_in,
	output logic got,
	output logic [7:0] got_byte,
	output logic got_atn
);
	// ************************************************************
	// Acceptor handshake.
	// ************************************************************
	int unsigned hold_q;

	// A released line reads high through its pull-up, so a held byte never looks accepted early.
	always_ff @(posedge clk) begin
		got <= 1'b0;
		if (rst) begin
			bus_in <= '{nrfd: 1'b1, ndac: 1'b0, srq: 1'b1};
			hold_q <= 0;
			got_byte <= 8'h00;
			got_atn <= 1'b0;
		end else if (bus_in.ndac) begin
			if (!bus_oe.dav) begin
				bus_in.ndac <= 1'b0;
				bus_in.nrfd <= 1'b1;
			end
		end else if (hold_q != 0) begin
			hold_q <= hold_q - 1;
			if (hold_q == 1)
				bus_in.ndac <= 1'b1;
		end else if (bus_oe.dav) begin
			got <= 1'b1;
			got_byte <= bus_oe.dio;
			got_atn <= bus_oe.atn;
			bus_in.nrfd <= 1'b0;
			hold_q <= $urandom_range(1, 40);
		end
	end
endmodule // bus_listener

// ### tb/test_parallel_port_gpib_sender.sv
/*
 * Self-checking bench: APB host driver, instrument bus listener, queued expectations.
 * Assumes the adapter answers APB in the second access cycle and resets synchronously.
 */
`timescale 1ns/1ns
module test_parallel_port_gpib_sender;
	import lpt_bus_pkg::*;
	localparam int IFC_SIM = 20;
	typedef struct packed {logic [31:0] data; logic [31:0] mask; logic err;} rd_note_t;
	typedef struct packed {logic atn; logic [7:0] data;} bus_note_t;
	logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, got, got_atn;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [7:0] got_byte, b;
	logic [4:0] la;
	gpib_in_t bus_in;
	gpib_pins_t bus_out, bus_oe;
	rd_note_t rd_q[$];
	bus_note_t bus_q[$];
	int n_mismatch = 0;
	int n_compared = 0;
	int n_irq = 0;

	parallel_port_gpib_sender #(.IFC_CYCLES_P(IFC_SIM)) i_parallel_port_gpib_sender (.clk(clk), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe), .irq(irq));
	bus_listener i_bus_listener (.clk(clk), .rst(rst), .bus_oe(bus_oe), .bus_in(bus_in), .got(got),
		.got_byte(got_byte), .got_atn(got_atn));

	// ************************************************************
	// Checking and closing.
	// ************************************************************
	task automatic check(input logic [31:0] v, input logic [31:0] e);
		n_compared++;
		if (v !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, v, e);
		end
	endtask

	task automatic summarize();
		$display("mismatches %0d compared %0d", n_mismatch, n_compared);
		if (n_mismatch == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	always @(posedge clk) begin : rd_watch
		rd_note_t n;
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			if (rd_q.size() == 0)
				check(32'h1, 32'h0);
			else begin
				n = rd_q.pop_front();
				if (n.mask != 0) begin
					check(prdata & n.mask, n.data);
					check({31'h0, pslverr}, {31'h0, n.err});
				end
			end
		end
	end

	always @(posedge clk) begin : bus_watch
		if (got === 1'b1) begin
			if (bus_q.size() == 0)
				check(32'h1, 32'h0);
			else
				check({23'h0, got_atn, got_byte}, {23'h0, bus_q.pop_front()});
		end
		if (irq === 1'b1)
			n_irq++;
	end

	// ************************************************************
	// Host driver.
	// ************************************************************
	// An idle cycle after each transfer keeps one assignment per signal per time step.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m, input logic err);
		logic [31:0] q;
		rd_q.push_back('{e, m, err});
		apb(1'b0, a, 32'h0000_0000, q);
	endtask

	task automatic wait_ready();
		logic [31:0] q;
		int i;
		for (i = 0; i < 1000; i++) begin
			rd_q.push_back('{32'h0, 32'h0, 1'b0});
			apb(1'b0, STATUS_ADDR, 32'h0000_0000, q);
			if (q[STAT_BUSY_N] === 1'b1)
				break;
		end
		check(32'(i == 1000), 32'h0);
	endtask

	task automatic send(input logic [7:0] v, input logic [31:0] hi, input logic [31:0] lo);
		wr(DATA_ADDR, {24'h0, v});
		wait_ready();
		wr(CTRL_ADDR, hi);
		rd(STATUS_ADDR, 32'h0, 32'h0000_0080, 1'b0);
		repeat (150) @(posedge clk);
		wr(CTRL_ADDR, lo);
		rd(STATUS_ADDR, 32'h0000_0040, 32'h0000_00c0, 1'b0);
	endtask

	// ************************************************************
	// Scenarios.
	// ************************************************************
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		repeat (60000) @(posedge clk);
		n_mismatch++;
		summarize();
	end

	initial begin
		rst = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		b = 8'($urandom(32'hd71f_b9cd));
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		wait_ready();
		rd(STATUS_ADDR, 32'h0000_00d8, 32'h0000_00f8, 1'b0);
		rd(CTRL_ADDR, 32'h0, 32'hffff_ffff, 1'b0);
		rd(CONFIG_ADDR, 32'h0000_0001, 32'h0000_003f, 1'b0);
		rd(12'h010, 32'h0, 32'hffff_ffff, 1'b1);
		la = 5'($urandom_range(0, 30));
		wr(CONFIG_ADDR, {27'h0, la});
		b = 8'($urandom);
		bus_q.push_back('{1'b1, LISTEN_BASE | {3'h0, la}});
		bus_q.push_back('{1'b0, b});
		send(b, 32'h0000_000d, 32'h0000_000c);
		wait_ready();
		check(32'(n_irq), 32'h0);
		b = 8'($urandom);
		bus_q.push_back('{1'b0, b});
		send(b, 32'h0000_00fd, 32'h0000_00fc);
		wait_ready();
		check(32'(n_irq), 32'h1);
		wr(CTRL_ADDR, 32'h0000_000c);
		wr(CONFIG_ADDR, {26'h0, 1'b1, la});
		b = 8'($urandom);
		bus_q.push_back('{1'b0, {^b[6:0], b[6:0]}});
		send(b, 32'h0000_000d, 32'h0000_000c);
		wr(CTRL_ADDR, 32'h0000_000d);
		wr(CTRL_ADDR, 32'h0000_000c);
		wait_ready();
		check(32'(n_irq), 32'h1);
		wr(CONFIG_ADDR, {27'h0, la});
		wr(CTRL_ADDR, 32'h0000_0008);
		repeat (4) @(posedge clk);
		check({31'h0, bus_oe.ifc}, 32'h1);
		wait_ready();
		b = 8'($urandom);
		bus_q.push_back('{1'b1, LISTEN_BASE | {3'h0, la}});
		bus_q.push_back('{1'b0, b});
		send(b, 32'h0000_000d, 32'h0000_000c);
		wait_ready();
		check(32'(bus_q.size()), 32'h0);
		check(32'(bus_out), 32'h0);
		check({30'h0, bus_oe.ren, bus_oe.eoi}, 32'h0000_0002);
		summarize();
	end
endmodule // test_parallel_port_gpib_sender
